// ==== hw/arsc_dev.sv ====
// Converter configuration end: range register, reference and sequencer
// Summary of operation
// - Seq bits equal: convert addressed channel
// - Seq 10: sweep channel 0 to final
// - Host starts sequence with seq 10
// - Sequence uses each channel's stored range
// - Sequencing continues without further writes
// - Any seq write other than 10 leaves sequence
// - Range register six bits, write-only
// - Range write needs bits 1,0,1
// - Range pairs at word positions 13/12, 9/8
// - Range codes: 10V, 5V, 2.5V, unipolar
// - Reset range is plus-minus 10 V
// - Selected channel gets its stored range
// - Reference bit 1 picks internal
// - Reference bit resets to external
// - First internal-enable conversion is invalid
// - Host waits 500 us after enabling; arsc_host only flags it in STATUS bit 1 and keeps sending words
// - Decode top three bits; range at 11th
// - Seq bits 3,2; channel bit 10
// - Sequence uses last reference and coding
`timescale 1ns/1ps
`default_nettype none
module arsc_dev (
    input  wire logic  pclk,            // System clock
    input  wire logic  presetn,         // Async reset, low
    arsc_if.dev        link,            // Serial link
    output logic [1:0] input_range_select_ch0, // Range of channel 0
    output logic [1:0] input_range_select_ch1, // Range of channel 1
    output logic       conv_channel,    // Channel of the frame now
    output logic [1:0] conv_range,      // Range applied to it
    output logic       internal_ref,    // Internal reference on
    output logic       straight_binary, // Output coding
    output logic       seq_active,      // Sequencer running
    output logic       result_invalid   // Frame result to discard
);
    // Bits still to come when each register is latched
    localparam int RSH = arsc_pkg::WORD_BITS - arsc_pkg::RANGE_LATCH_EDGE;
    localparam int CSH = arsc_pkg::WORD_BITS - arsc_pkg::CTRL_LATCH_EDGE;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_SEQ_FIRST,
        MODE_SEQ_RUN
    } arsc_mode_t;

    // Register targeted by a three-bit header
    function automatic logic arsc_is_range(input logic [2:0] hdr);
        return hdr == 3'b101;
    endfunction

    function automatic logic arsc_is_ctrl(input logic [2:0] hdr);
        return hdr == 3'b100;
    endfunction

    // Stored range pair of one channel
    function automatic logic [1:0] arsc_range_of(input logic [5:0] r,
                                                 input logic       ch);
        return ch ? r[1:0] : r[5:4];
    endfunction

    logic [15:0] word;
    logic [4:0]  count;
    logic        fall;
    logic        cs_ff;
    logic [5:0]  range_ff;
    logic [5:0]  nxt_range;
    logic        chaddr_ff;
    logic        ref_ff;
    logic        coding_ff;
    logic        seq_ff;
    arsc_mode_t  mode_ff;
    arsc_mode_t  nxt_mode;
    logic        chan_ff;
    logic        nxt_chan;
    logic [1:0]  crange_ff;
    logic [1:0]  nxt_crange;
    logic        ref_seen_ff;
    logic        invalid_ff;

    arsc_shift u_shift (
        .pclk    (pclk),
        .presetn (presetn),
        .cs_n    (link.cs_n),
        .sclk    (link.sclk),
        .din     (link.din),
        .word    (word),
        .count   (count),
        .fall    (fall)
    );

    // Word as it stands after the current falling edge
    wire [15:0] cur       = {word[14:0], link.din};
    wire [2:0]  range_hdr = cur[arsc_pkg::RANGE_LATCH_EDGE - 1 -: 3];
    wire [2:0]  ctrl_hdr  = cur[arsc_pkg::CTRL_LATCH_EDGE - 1 -: 3];
    wire at_range  = fall && count == 5'(arsc_pkg::RANGE_LATCH_EDGE - 1);
    wire at_ctrl   = fall && count == 5'(arsc_pkg::CTRL_LATCH_EDGE - 1);
    wire range_hit = at_range && arsc_is_range(range_hdr);
    wire ctrl_hit  = at_ctrl && arsc_is_ctrl(ctrl_hdr);

    // Range pairs, shifted down by the bits still to come
    wire [1:0] w_ch0 = {cur[arsc_pkg::RANGE_CH0_HI - RSH],
                        cur[arsc_pkg::RANGE_CH0_LO - RSH]};
    wire [1:0] w_ch1 = {cur[arsc_pkg::RANGE_CH1_HI - RSH],
                        cur[arsc_pkg::RANGE_CH1_LO - RSH]};
    assign nxt_range = {w_ch0, 2'b00, w_ch1};

    // Control word bits, one place down at the 15th fall
    wire c_seq_hi = cur[arsc_pkg::BIT_SEQ_HI - CSH];
    wire c_seq_lo = cur[arsc_pkg::BIT_SEQ_LO - CSH];
    wire c_chaddr = cur[arsc_pkg::BIT_CHADDR - CSH];
    wire c_ref    = cur[arsc_pkg::BIT_REF - CSH];
    wire c_coding = cur[arsc_pkg::BIT_CODING - CSH];

    wire frame_start = cs_ff & ~link.cs_n;
    wire last_chan   = chan_ff == chaddr_ff;
    wire first_ref   = ctrl_hit && c_ref && !ref_seen_ff;
    assign nxt_crange = arsc_range_of(range_ff, nxt_chan);

    // Mode moves on a control write or at the first frame start after entry; 11 counts as single
    always_comb begin
        nxt_mode = mode_ff;
        if (ctrl_hit) begin
            case ({c_seq_hi, c_seq_lo})
                2'b10: begin
                    // Entering restarts at channel 0
                    if (mode_ff == MODE_SINGLE) begin
                        nxt_mode = MODE_SEQ_FIRST;
                    end
                end
                2'b00: begin
                    nxt_mode = MODE_SINGLE;
                end
                default: begin
                    nxt_mode = MODE_SINGLE;
                end
            endcase
        end else if (frame_start && mode_ff == MODE_SEQ_FIRST) begin
            nxt_mode = MODE_SEQ_RUN;
        end
    end

    // Channel for the frame that starts now
    always_comb begin
        case (mode_ff)
            MODE_SEQ_FIRST: nxt_chan = 1'b0;
            MODE_SEQ_RUN:   nxt_chan = last_chan ? 1'b0 : ~chan_ff;
            MODE_SINGLE:    nxt_chan = chaddr_ff;
            default:        nxt_chan = chaddr_ff;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_ff   <= 1'b1;
            mode_ff <= MODE_SINGLE;
            seq_ff  <= 1'b0;
        end else begin
            cs_ff   <= link.cs_n;
            mode_ff <= nxt_mode;
            seq_ff  <= nxt_mode != MODE_SINGLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_ff <= arsc_pkg::RANGE_RESET;
        end else if (range_hit) begin
            range_ff <= nxt_range;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chaddr_ff <= 1'b0;
            ref_ff    <= 1'b0;
            coding_ff <= 1'b0;
        end else if (ctrl_hit) begin
            chaddr_ff <= c_chaddr;
            ref_ff    <= c_ref;
            coding_ff <= c_coding;
        end
    end

    // Sequencer steps on every frame, written or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_ff   <= 1'b0;
            crange_ff <= 2'h0;
        end else if (frame_start) begin
            chan_ff   <= nxt_chan;
            crange_ff <= nxt_crange;
        end
    end

    // Only the first enable after reset spoils its frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_seen_ff <= 1'b0;
            invalid_ff  <= 1'b0;
        end else begin
            if (first_ref) begin
                ref_seen_ff <= 1'b1;
            end
            if (first_ref) begin
                invalid_ff <= 1'b1;
            end else if (frame_start) begin
                invalid_ff <= 1'b0;
            end
        end
    end

    assign input_range_select_ch0 = range_ff[5:4];
    assign input_range_select_ch1 = range_ff[1:0];
    assign conv_channel    = chan_ff;
    assign conv_range      = crange_ff;
    assign internal_ref    = ref_ff;
    assign straight_binary = coding_ff;
    assign seq_active      = seq_ff;
    assign result_invalid  = invalid_ff;
endmodule
`default_nettype wire

// ==== hw/arsc_host.sv ====
// Host end: APB-commanded serial word writer
`timescale 1ns/1ps
`default_nettype none
module arsc_host (
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB enable
    input  wire logic        pwrite,   // APB direction
    input  wire logic [7:0]  paddr,    // APB address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic [31:0]      prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error
    arsc_if.host             link      // Serial link
);
    logic [31:0] prdata_ff;
    logic        busy_ff;
    logic [15:0] sh_ff;
    logic [15:0] last_ff;
    logic [4:0]  bits_ff;
    logic [2:0]  div_ff;
    logic        sclk_ff;
    logic        cs_ff;
    logic        ref_wait_ff;
    logic [14:0] wait_ff;

    wire acc   = psel & penable;
    wire wr_cmd = acc & pwrite & paddr == arsc_pkg::A_CMD & ~busy_ff;
    wire bad   = acc & ~(paddr == arsc_pkg::A_CMD
                       | paddr == arsc_pkg::A_STATUS
                       | paddr == arsc_pkg::A_LAST);
    wire tick  = div_ff == 3'(arsc_pkg::SCLK_HALF - 1);
    // Setting reference bit starts settle wait
    wire ref_on = wr_cmd & pwdata[arsc_pkg::BIT_WRITE]
                  & pwdata[arsc_pkg::BIT_REF];
    wire [31:0] rd_w = paddr == arsc_pkg::A_STATUS ?
                       {30'h0, ref_wait_ff, busy_ff} :
                       paddr == arsc_pkg::A_LAST ? {16'h0, last_ff} :
                       32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff   <= 32'h0000_0000;
            busy_ff     <= 1'b0;
            sh_ff       <= 16'h0000;
            last_ff     <= 16'h0000;
            bits_ff     <= 5'h00;
            div_ff      <= 3'h0;
            sclk_ff     <= 1'b1;
            cs_ff       <= 1'b1;
            ref_wait_ff <= 1'b0;
            wait_ff     <= 15'h0000;
        end else begin
            prdata_ff <= rd_w;
            if (ref_on) begin
                ref_wait_ff <= 1'b1;
                wait_ff     <= 15'(arsc_pkg::REF_WAIT_CYCLES - 1);
            end else if (wait_ff != 15'h0000) begin
                wait_ff <= wait_ff - 15'h0001;
            end else begin
                ref_wait_ff <= 1'b0;
            end
            if (wr_cmd) begin
                // Word sent as given: 101 header for range, 100 control
                sh_ff   <= pwdata[15:0];
                last_ff <= pwdata[15:0];
                busy_ff <= 1'b1;
                cs_ff   <= 1'b0;
                bits_ff <= 5'h00;
                div_ff  <= 3'h0;
            end else if (busy_ff) begin
                div_ff <= tick ? 3'h0 : div_ff + 3'h1;
                if (tick) begin
                    if (bits_ff == 5'h10) begin
                        cs_ff   <= 1'b1;
                        busy_ff <= 1'b0;
                    end else if (sclk_ff) begin
                        sclk_ff <= 1'b0;
                    end else begin
                        sclk_ff <= 1'b1;
                        sh_ff   <= {sh_ff[14:0], 1'b0};
                        bits_ff <= bits_ff + 5'h01;
                    end
                end
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = bad;
    assign link.cs_n = cs_ff;
    assign link.sclk = sclk_ff;
    assign link.din  = sh_ff[15];
endmodule
`default_nettype wire

// ==== hw/arsc_shift.sv ====
// Input shifter: counts falling serial edges and collects the word
`timescale 1ns/1ps
`default_nettype none
module arsc_shift (
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, low
    input  wire logic        cs_n,     // Frame select, low active
    input  wire logic        sclk,     // Serial clock, sampled
    input  wire logic        din,      // Serial data
    output logic [15:0]      word,     // Bits shifted so far
    output logic [4:0]       count,    // Falling edges in frame
    output logic             fall      // Falling edge this cycle
);
    logic sclk_ff;
    logic [15:0] word_ff;
    logic [4:0]  count_ff;
    wire fall_w = sclk_ff & ~sclk & ~cs_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_ff  <= 1'b1;
            word_ff  <= 16'h0000;
            count_ff <= 5'h00;
        end else begin
            sclk_ff <= sclk;
            if (cs_n) begin
                count_ff <= 5'h00;
            end else if (fall_w && count_ff != 5'h10) begin
                word_ff  <= {word_ff[14:0], din};
                count_ff <= count_ff + 5'h01;
            end
        end
    end
    assign word  = word_ff;
    assign count = count_ff;
    assign fall  = fall_w && count_ff != 5'h10;
endmodule
`default_nettype wire

// ==== pkg/arsc_if.sv ====
// Serial link between the host controller and the converter logic
`timescale 1ns/1ps
`default_nettype none
interface arsc_if;
    logic cs_n;
    logic sclk;
    logic din;
    modport host (output cs_n, output sclk, output din);
    modport dev  (input cs_n, input sclk, input din);
endinterface
`default_nettype wire

// ==== pkg/arsc_pkg.sv ====
// Shared constants for the range/sequencer configuration link
package arsc_pkg;
    localparam int WORD_BITS   = 16;
    // Word field positions, 15 = first bit shifted
    localparam int BIT_WRITE   = 15;
    localparam int BIT_ZERO    = 14;
    localparam int BIT_REGSEL  = 13;
    localparam int BIT_CHADDR  = 10;
    localparam int BIT_CODING  = 5;
    localparam int BIT_REF     = 4;
    localparam int BIT_SEQ_HI  = 3;
    localparam int BIT_SEQ_LO  = 2;
    // Range word: ch0 pair at printed 13/12, ch1 at 9/8 (first bit is 16)
    localparam int RANGE_CH0_HI = 12;
    localparam int RANGE_CH0_LO = 11;
    localparam int RANGE_CH1_HI = 8;
    localparam int RANGE_CH1_LO = 7;
    localparam int RANGE_LATCH_EDGE = 11;
    localparam int CTRL_LATCH_EDGE  = 15;
    localparam logic [5:0] RANGE_RESET = 6'h00;
    localparam logic [1:0] RNG_PM10    = 2'h0;
    localparam logic [1:0] RNG_PM5     = 2'h1;
    localparam logic [1:0] RNG_PM2P5   = 2'h2;
    localparam logic [1:0] RNG_UNI10   = 2'h3;
    // Host timing
    localparam int CLK_MHZ         = 50;
    localparam int SCLK_HALF       = 4;
    localparam int REF_WAIT_US     = 500;
    localparam int REF_WAIT_CYCLES = REF_WAIT_US * CLK_MHZ;
    // Host APB map
    localparam logic [7:0] A_CMD    = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_LAST   = 8'h08;
endpackage

// ==== verification/adc_range_sequencer_config_test.sv ====
// Self-checking bench for the range and sequencer configuration link
`timescale 1ns/1ps
`default_nettype none
module adc_range_sequencer_config_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [1:0]  rc0, rc1, crng, cc;
    logic        cch, iref, sbin, sact, rinv;
    int          error_cnt = 0;
    int          compares = 0;
    arsc_if lnk ();
    always #10 pclk = ~pclk;
    arsc_host u_arsc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    arsc_dev u_arsc_dev (.pclk(pclk), .presetn(presetn), .link(lnk),
        .input_range_select_ch0(rc0), .input_range_select_ch1(rc1),
        .conv_channel(cch), .conv_range(crng), .internal_ref(iref),
        .straight_binary(sbin), .seq_active(sact), .result_invalid(rinv));
    arsc_chk u_arsc_chk (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .din(lnk.din), .input_range_select_ch0(rc0),
        .input_range_select_ch1(rc1), .conv_channel(cch), .conv_range(crng),
        .internal_ref(iref), .seq_active(sact), .result_invalid(rinv));
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Send one word, then poll until the frame is over
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        apb(1'b1, arsc_pkg::A_CMD, {16'h0000, w});
        do begin
            apb(1'b0, arsc_pkg::A_STATUS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        if (n >= 200) begin
            error_cnt++;
            test_done();
        end
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({rc0, rc1, iref, sact}, 6'h00);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk(err, 1'b1);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            cc = c[1:0];
            send({3'b101, cc, 2'b00, ~cc, 7'h00});
            chk({rc0, rc1}, {cc, ~cc});
        end
        send(16'hA900);
        chk({rc0, rc1}, {arsc_pkg::RNG_PM5, arsc_pkg::RNG_PM2P5});
        apb(1'b0, arsc_pkg::A_LAST, 32'h0000_0000);
        chk(rd, 32'h0000_A900);
        send(16'hF980);
        send(16'h3980);
        chk({rc0, rc1}, 4'b0110);
        $display("range test done");
        send(16'h8400);
        send(16'h0000);
        chk({cch, crng}, 3'b110);
        send(16'h800C);
        send(16'h0000);
        chk({cch, crng, sact}, 4'b0010);
        $display("single test done");
        send(16'h8438);
        chk({sact, iref, rinv, sbin}, 4'b1111);
        apb(1'b0, arsc_pkg::A_STATUS, 32'h0000_0000);
        chk(rd[1], 1'b1);
        send(16'h0000);
        chk({cch, crng, rinv}, 4'b0010);
        send(16'h7FFF);
        chk({cch, crng, sact, iref}, 5'b11011);
        send(16'h0000);
        chk({cch, crng}, 3'b001);
        repeat (arsc_pkg::REF_WAIT_CYCLES) @(posedge pclk);
        apb(1'b0, arsc_pkg::A_STATUS, 32'h0000_0000);
        chk(rd[1], 1'b0);
        send(16'h8000);
        chk({sact, iref, sbin}, 3'b000);
        send(16'h0000);
        chk(cch, 1'b0);
        $display("sequence test done");
        test_done();
    end
endmodule
`default_nettype wire

// ==== verification/arsc_chk.sv ====
// Concurrent checks on the serial link and the converter end
`timescale 1ns/1ps
`default_nettype none
module arsc_chk (
    input wire logic       pclk,                   // System clock
    input wire logic       presetn,                // Async reset, low
    input wire logic       cs_n,                   // Frame select
    input wire logic       sclk,                   // Serial clock
    input wire logic       din,                    // Serial data
    input wire logic [1:0] input_range_select_ch0, // Range ch0
    input wire logic [1:0] input_range_select_ch1, // Range ch1
    input wire logic       conv_channel,           // Frame channel
    input wire logic [1:0] conv_range,             // Frame range
    input wire logic       internal_ref,           // Reference choice
    input wire logic       seq_active,             // Sequencer on
    input wire logic       result_invalid          // Discard flag
);
    logic        sclk_ff;
    logic        fall_ff;
    logic [4:0]  cnt_ff;
    logic [15:0] sh_ff;
    logic [3:0]  win_ff;
    logic        seen_ff;
    wire         fall = sclk_ff & ~sclk & ~cs_n;
    wire         ctl  = fall_ff && cnt_ff == 5'd15 && sh_ff[14:12] == 3'b100;
    wire         rng  = fall_ff && cnt_ff == 5'd11 && sh_ff[10:8] == 3'b101;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_ff <= 1'b1;
            fall_ff <= 1'b0;
            cnt_ff  <= 5'h0;
            sh_ff   <= 16'h0000;
            win_ff  <= 4'h0;
            seen_ff <= 1'b0;
        end else begin
            seen_ff <= seen_ff | (ctl && sh_ff[3]);
            sclk_ff <= sclk;
            fall_ff <= fall;
            cnt_ff  <= cs_n ? 5'h0 : cnt_ff + {4'h0, fall};
            sh_ff   <= fall ? {sh_ff[14:0], din} : sh_ff;
            // Window after an 11th fall in which ranges may move
            win_ff  <= (fall && cnt_ff == 5'd10) ? 4'h8
                       : win_ff - {3'h0, win_ff != 4'h0};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_range_latch;
        rng |-> ##[0:4] (input_range_select_ch0 == sh_ff[7:6]
                         && input_range_select_ch1 == sh_ff[3:2]);
    endproperty
    a_range_latch: assert property (p_range_latch)
        else $error("range pairs not taken from word");
    property p_range_only;
        $changed(input_range_select_ch0) || $changed(input_range_select_ch1)
            |-> win_ff != 4'h0;
    endproperty
    a_range_only: assert property (p_range_only)
        else $error("range moved without a range word");
    property p_seq_on;
        ctl && sh_ff[2:1] == 2'b10 |-> ##[0:4] seq_active;
    endproperty
    a_seq_on: assert property (p_seq_on)
        else $error("sequencer not started");
    property p_seq_off;
        ctl && sh_ff[2:1] == 2'b00 |-> ##[0:4] !seq_active;
    endproperty
    a_seq_off: assert property (p_seq_off)
        else $error("sequencer not stopped");
    property p_ref;
        ctl |-> ##[0:4] internal_ref == sh_ff[3];
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference choice not taken");
    property p_inval;
        ctl && sh_ff[3] && !seen_ff |-> ##[0:4] result_invalid;
    endproperty
    a_inval: assert property (p_inval)
        else $error("first internal frame not flagged");
    property p_conv;
        $fell(cs_n) |-> ##[1:2] conv_range == (conv_channel ?
            input_range_select_ch1 : input_range_select_ch0);
    endproperty
    a_conv: assert property (p_conv)
        else $error("frame range differs from stored range");
    property p_frame;
        $rose(cs_n) |-> cnt_ff == 5'd16;
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame not sixteen falls long");
endmodule
`default_nettype wire
